// File: hw/fsp_pkg.sv
// fsp_pkg: constants and carrier types for the flash self-programming controller
// assumes: 8-bit special-function-register bus, 16-bit flash address, 512-byte pages
package fsp_pkg;

  // ==========================================================
  // register addresses
  localparam logic [7:0] ADDR_SYS_CTRL  = 8'hbf;
  localparam logic [7:0] ADDR_ADDR_HIGH = 8'hf4;
  localparam logic [7:0] ADDR_ADDR_LOW  = 8'hf5;
  localparam logic [7:0] ADDR_DATA      = 8'hf6;
  localparam logic [7:0] ADDR_CTRL      = 8'hf7;

  // ==========================================================
  // field positions
  localparam int SYS_WDR_BIT  = 7;
  localparam int SYS_SELF_PROGRAM_ENABLE_BIT = 2;
  localparam int SYS_XRAM_BIT = 1;
  localparam int SYS_LATCH_STROBE_INHIBIT_BIT = 0;
  localparam int CTRL_GO_BIT  = 7;

  // ==========================================================
  // reset values
  localparam logic [7:0] SYS_CTRL_RESET = 8'h00;
  localparam logic [7:0] BYTE_RESET     = 8'h00;

  // ==========================================================
  // unlock sequence and page geometry
  localparam logic [7:0] UNLOCK_FIRST   = 8'h55;
  localparam logic [7:0] UNLOCK_SECOND  = 8'haa;
  localparam int         PAGE_BYTES     = 512;
  localparam int         PAGE_SHIFT     = 9;
  localparam int         MAX_BOOT_PAGES = 8;
  localparam logic [7:0] BLANK_BYTE     = 8'hff;
  localparam logic [7:0] PAGE_LOW_ZERO  = 8'h00;

  // ==========================================================
  // timing
  localparam int CLOCK_MHZ    = 250;
  localparam int OP_TIME_US   = 20;
  localparam int OP_CYCLES    = OP_TIME_US * CLOCK_MHZ;

  typedef enum logic [1:0] {
    FSP_FN_BYTE_PROG,
    FSP_FN_PROTECT,
    FSP_FN_PAGE_ERASE,
    FSP_FN_CHIP_ERASE
  } fsp_fn_e;

  // command handed to the flash array
  typedef struct packed {
    fsp_fn_e     func;
    logic [15:0] addr;
    logic [7:0]  data;
  } fsp_cmd_s;

endpackage

// File: hw/fsp_ctrl.sv
// fsp_ctrl: boot zone decode, reset vector choice and self-programming sequencer
// assumes: core register bus on i_clock, flash array answers done pulses, straps stable
//
// What this block does
// [R1] boot zone is page count times 512 bytes, at the top of flash
// [R2] parallel programmer whole erase clears all flash, boot zone included
// [R3] nonzero boot pages and blank location zero start fetch at zone base
// [R4] zero boot pages reserves nothing and never redirects reset
// [R5] boot zone kept from self erase whether or not locked; lock bit blocks readback
// [R6] self-programming disabled after reset; system control bit 2 enables it
// [R7] system control bit 7 sets on watchdog overflow reset
// [R8] system control bit 1 enables the 768-byte extended data RAM
// [R9] system control bit 0 suppresses the address latch strobe
// [R10] target address from high byte at F4 and low byte at F5
// [R11] data byte for the operation held at F6
// [R12] writing 1 to control bit 7 launches the selected function
// [R13] start ignored while enable clear; unused control bits read zero
// [R14] function select: 00 program, 01 protect, 10 page erase, 11 chip erase
// [R15] start writable only after 55h, AAh, 55h written to data register
// [R16] latch address and data, stall core until done or the OP_CYCLES timer runs out, then clear start
// [R17] page erase clears 512-byte page; boot pages never page-erased
`timescale 1ns/1ns
module fsp_ctrl #(
  parameter int OP_CYCLES = fsp_pkg::OP_CYCLES
) (
  input  wire logic             i_clock,
  input  wire logic             i_nrst,
  // core register bus
  input  wire logic [7:0]       i_reg_addr,
  input  wire logic             i_reg_wr,
  input  wire logic             i_reg_rd,
  input  wire logic [7:0]       i_reg_wdata,
  output logic      [7:0]       o_reg_rdata,
  output logic                  o_reg_hit,
  // reset cause and configuration straps
  input  wire logic             i_wdt_reset,
  input  wire logic [3:0]       i_boot_pages,
  input  wire logic             i_lock_bit,
  input  wire logic [7:0]       i_flash_loc0,
  input  wire logic             i_pp_erase,
  // processor control
  output logic                  o_boot_start,
  output logic      [15:0]      o_reset_vector,
  output logic                  o_cpu_stall,
  output logic                  o_xram_enable,
  output logic                  o_ale_inhibit,
  output logic                  o_read_block,
  // flash array
  output logic                  o_flash_req,
  output fsp_pkg::fsp_cmd_s     o_flash_cmd,
  output logic                  o_flash_full_erase,
  output logic      [15:0]      o_erase_lo,
  output logic      [15:0]      o_erase_hi,
  input  wire logic             i_flash_done
);

  // ==========================================================
  // synchronise external levels
  logic [1:0] wdt_sync_reg;
  logic [1:0] pp_sync_reg;
  always_ff @(posedge i_clock or negedge i_nrst) begin
    if (!i_nrst) begin
      wdt_sync_reg <= 2'h0;
      pp_sync_reg  <= 2'h0;
    end else begin
      wdt_sync_reg <= {wdt_sync_reg[0], i_wdt_reset};
      pp_sync_reg  <= {pp_sync_reg[0], i_pp_erase};
    end
  end

  // ==========================================================
  // straps caught once after reset release
  logic        strap_taken_reg;
  logic [3:0]  pages_reg;
  logic        lock_reg;
  logic        loc0_blank_reg;
  always_ff @(posedge i_clock or negedge i_nrst) begin
    if (!i_nrst) begin
      strap_taken_reg <= 1'b0;
      pages_reg       <= 4'h0;
      lock_reg        <= 1'b0;
      loc0_blank_reg  <= 1'b0;
    end else if (!strap_taken_reg) begin
      strap_taken_reg <= 1'b1;
      pages_reg       <= (i_boot_pages > 4'(fsp_pkg::MAX_BOOT_PAGES)) ?
                         4'(fsp_pkg::MAX_BOOT_PAGES) : i_boot_pages;
      lock_reg        <= i_lock_bit;
      loc0_blank_reg  <= (i_flash_loc0 == fsp_pkg::BLANK_BYTE);
    end
  end

  // ==========================================================
  // boot zone
  // [R1] zone base from page count
  function automatic logic [15:0] zone_base(input logic [3:0] pages);
    logic [16:0] size;
    size = 17'(pages) << fsp_pkg::PAGE_SHIFT;
    zone_base = 16'(17'h10000 - size);
  endfunction

  logic [15:0] boot_base;
  logic        zone_on;
  assign boot_base = zone_base(pages_reg);
  // [R4] zero pages means no zone
  assign zone_on   = (pages_reg != 4'h0);

  // [R3] reset vector choice
  assign o_boot_start   = strap_taken_reg && zone_on && loc0_blank_reg;
  assign o_reset_vector = o_boot_start ? boot_base : 16'h0000;
  // [R5] readback block under lock
  assign o_read_block   = lock_reg;

  // [R2] whole erase from the parallel programmer
  assign o_flash_full_erase = pp_sync_reg[1];

  // ==========================================================
  // system control register
  logic       wdr_reg;
  logic       self_program_enable_reg;
  logic       xram_reg;
  logic       latch_strobe_inhibit_reg;
  logic       sys_wr;
  assign sys_wr = i_reg_wr && (i_reg_addr == fsp_pkg::ADDR_SYS_CTRL);

  // [R7] watchdog flag, set wins over clear
  always_ff @(posedge i_clock or negedge i_nrst) begin
    if (!i_nrst) begin
      wdr_reg <= 1'b0;
    end else if (wdt_sync_reg[1]) begin
      wdr_reg <= 1'b1;
    end else if (sys_wr) begin
      wdr_reg <= i_reg_wdata[fsp_pkg::SYS_WDR_BIT];
    end
  end

  // [R6] enable off at reset
  always_ff @(posedge i_clock or negedge i_nrst) begin
    if (!i_nrst) begin
      self_program_enable_reg <= 1'b0;
      xram_reg <= 1'b0;
      latch_strobe_inhibit_reg <= 1'b0;
    end else if (sys_wr) begin
      self_program_enable_reg <= i_reg_wdata[fsp_pkg::SYS_SELF_PROGRAM_ENABLE_BIT];
      xram_reg <= i_reg_wdata[fsp_pkg::SYS_XRAM_BIT];
      latch_strobe_inhibit_reg <= i_reg_wdata[fsp_pkg::SYS_LATCH_STROBE_INHIBIT_BIT];
    end
  end
  // [R8] extended RAM enable
  assign o_xram_enable = xram_reg;
  // [R9] strobe inhibit
  assign o_ale_inhibit = latch_strobe_inhibit_reg;

  // ==========================================================
  // address, data and function registers
  logic [7:0] addr_hi_reg;
  logic [7:0] addr_lo_reg;
  logic [7:0] data_reg;
  logic [1:0] func_reg;
  logic       busy_reg;

  // [R10] address bytes
  // [R11] data byte
  always_ff @(posedge i_clock or negedge i_nrst) begin
    if (!i_nrst) begin
      addr_hi_reg <= fsp_pkg::BYTE_RESET;
      addr_lo_reg <= fsp_pkg::BYTE_RESET;
      data_reg    <= fsp_pkg::BYTE_RESET;
      func_reg    <= 2'h0;
    end else if (i_reg_wr && !busy_reg) begin
      if (i_reg_addr == fsp_pkg::ADDR_ADDR_HIGH) begin
        addr_hi_reg <= i_reg_wdata;
      end else if (i_reg_addr == fsp_pkg::ADDR_ADDR_LOW) begin
        addr_lo_reg <= i_reg_wdata;
      end else if (i_reg_addr == fsp_pkg::ADDR_DATA) begin
        data_reg <= i_reg_wdata;
      end else if (i_reg_addr == fsp_pkg::ADDR_CTRL) begin
        func_reg <= i_reg_wdata[1:0];
      end
    end
  end

  // ==========================================================
  // unlock sequence tracker
  logic [1:0] unlock_reg;
  logic       data_wr;
  logic       ctrl_wr;
  logic       go_req;
  assign data_wr = i_reg_wr && (i_reg_addr == fsp_pkg::ADDR_DATA);
  assign ctrl_wr = i_reg_wr && (i_reg_addr == fsp_pkg::ADDR_CTRL);
  // [R12] start request on control bit 7
  // [R13] ignored while disabled
  // [R15] only once unlocked
  assign go_req  = ctrl_wr && i_reg_wdata[fsp_pkg::CTRL_GO_BIT] && self_program_enable_reg &&
                   (unlock_reg == 2'h3) && !busy_reg;

  // [R15] count 55h, AAh, 55h; other data writes restart until unlocked, then unlocked holds until a start is accepted
  always_ff @(posedge i_clock or negedge i_nrst) begin
    if (!i_nrst) begin
      unlock_reg <= 2'h0;
    end else if (go_req) begin
      unlock_reg <= 2'h0;
    end else if (data_wr && !busy_reg) begin
      case (unlock_reg)
        2'h0: unlock_reg <= (i_reg_wdata == fsp_pkg::UNLOCK_FIRST) ? 2'h1 : 2'h0;
        2'h1: unlock_reg <= (i_reg_wdata == fsp_pkg::UNLOCK_SECOND) ? 2'h2 :
                            ((i_reg_wdata == fsp_pkg::UNLOCK_FIRST) ? 2'h1 : 2'h0);
        2'h2: unlock_reg <= (i_reg_wdata == fsp_pkg::UNLOCK_FIRST) ? 2'h3 : 2'h0;
        default: unlock_reg <= 2'h3;
      endcase
    end
  end

  // ==========================================================
  // operation sequencer
  typedef enum logic [1:0] {
    FSP_IDLE,
    FSP_ISSUE,
    FSP_WAIT
  } fsp_state_e;

  localparam int CW = $clog2(OP_CYCLES + 1);
  fsp_state_e        state_reg;
  fsp_pkg::fsp_cmd_s cmd_reg;
  logic [CW-1:0]     timer_reg;
  logic              skip;

  // [R17] page erase inside boot zone is refused
  // [R5] chip erase is never refused here, locked or not
  always_comb begin
    skip = 1'b0;
    if (zone_on && (cmd_reg.func == fsp_pkg::FSP_FN_PAGE_ERASE) &&
        (cmd_reg.addr >= boot_base)) begin
      skip = 1'b1;
    end
  end

  // [R16] latch, stall, then clear start
  always_ff @(posedge i_clock or negedge i_nrst) begin
    if (!i_nrst) begin
      state_reg <= FSP_IDLE;
      cmd_reg   <= '0;
      busy_reg  <= 1'b0;
      timer_reg <= '0;
    end else begin
      case (state_reg)
        FSP_IDLE: begin
          if (go_req) begin
            // [R14] function decode
            cmd_reg.func <= fsp_pkg::fsp_fn_e'(i_reg_wdata[1:0]);
            cmd_reg.addr <= {addr_hi_reg, addr_lo_reg};
            cmd_reg.data <= data_reg;
            busy_reg     <= 1'b1;
            state_reg    <= FSP_ISSUE;
          end
        end
        FSP_ISSUE: begin
          timer_reg <= CW'(OP_CYCLES);
          state_reg <= skip ? FSP_IDLE : FSP_WAIT;
          busy_reg  <= !skip;
        end
        default: begin
          if (i_flash_done || timer_reg == '0) begin
            busy_reg  <= 1'b0;
            state_reg <= FSP_IDLE;
          end else begin
            timer_reg <= timer_reg - CW'(1);
          end
        end
      endcase
    end
  end

  assign o_cpu_stall = busy_reg;
  assign o_flash_req = (state_reg == FSP_ISSUE) && !skip;
  assign o_flash_cmd = cmd_reg;

  // [R17] page span from high byte, even-aligned 512 bytes
  // [R5] chip erase keeps boot zone, locked or not
  always_comb begin
    o_erase_lo = 16'h0000;
    o_erase_hi = 16'hffff;
    if (cmd_reg.func == fsp_pkg::FSP_FN_PAGE_ERASE) begin
      o_erase_lo = {cmd_reg.addr[15:9], 9'h000};
      o_erase_hi = {cmd_reg.addr[15:9], 9'h1ff};
    end else if (cmd_reg.func == fsp_pkg::FSP_FN_CHIP_ERASE && zone_on && lock_reg) begin
      o_erase_hi = 16'(boot_base - 16'h0001);
    end else if (cmd_reg.func == fsp_pkg::FSP_FN_CHIP_ERASE && zone_on) begin
      o_erase_hi = 16'(boot_base - 16'h0001);
    end
  end

  // ==========================================================
  // read-back
  always_comb begin
    o_reg_rdata = 8'h00;
    o_reg_hit   = 1'b1;
    if (i_reg_addr == fsp_pkg::ADDR_SYS_CTRL) begin
      o_reg_rdata = {wdr_reg, 4'h0, self_program_enable_reg, xram_reg, latch_strobe_inhibit_reg};
    end else if (i_reg_addr == fsp_pkg::ADDR_ADDR_HIGH) begin
      o_reg_rdata = addr_hi_reg;
    end else if (i_reg_addr == fsp_pkg::ADDR_ADDR_LOW) begin
      o_reg_rdata = addr_lo_reg;
    end else if (i_reg_addr == fsp_pkg::ADDR_DATA) begin
      o_reg_rdata = data_reg;
    end else if (i_reg_addr == fsp_pkg::ADDR_CTRL) begin
      // [R13] unused bits zero
      o_reg_rdata = {busy_reg, 5'h00, func_reg};
    end else begin
      o_reg_hit = 1'b0;
    end
    if (!i_reg_rd) begin
      o_reg_hit = 1'b0;
    end
  end

endmodule

// File: tb/fsp_ctrl_checker.sv
// fsp_ctrl_checker: port-level timing relations of the flash self-program controller
// assumes: straps change only while i_nrst is low
`timescale 1ns/1ns
module fsp_ctrl_checker #(
  parameter int OP_CYCLES = 8
) (
  input wire logic              i_clock,
  input wire logic              i_nrst,
  input wire logic [7:0]        i_reg_addr,
  input wire logic              i_reg_wr,
  input wire logic              i_reg_rd,
  input wire logic [7:0]        i_reg_wdata,
  input wire logic [7:0]        o_reg_rdata,
  input wire logic [3:0]        i_boot_pages,
  input wire logic              i_pp_erase,
  input wire logic              o_boot_start,
  input wire logic [15:0]       o_reset_vector,
  input wire logic              o_cpu_stall,
  input wire logic              o_xram_enable,
  input wire logic              o_ale_inhibit,
  input wire logic              o_flash_req,
  input wire fsp_pkg::fsp_cmd_s o_flash_cmd,
  input wire logic              o_flash_full_erase,
  input wire logic [15:0]       o_erase_lo,
  input wire logic [15:0]       o_erase_hi,
  input wire logic              i_flash_done
);
  // ==========================================================
  // boot zone helpers
  logic [3:0]  pages;
  logic [15:0] base;
  logic        zone_erase;
  assign pages = (i_boot_pages > 4'h8) ? 4'h8 : i_boot_pages;
  assign base = 16'h0000 - {3'h0, pages, 9'h000};
  assign zone_erase = (o_flash_cmd.func == fsp_pkg::FSP_FN_PAGE_ERASE) && (pages != 4'h0)
                      && (o_flash_cmd.addr >= base);
  default clocking @(posedge i_clock); endclocking
  default disable iff (!i_nrst);
  sequence s_finish;
    o_cpu_stall && i_flash_done;
  endsequence
  sequence s_sys_write;
    i_reg_wr && (i_reg_addr == fsp_pkg::ADDR_SYS_CTRL);
  endsequence
  // ==========================================================
  // properties
  property p_vector;
    o_boot_start |-> o_reset_vector == base;
  endproperty
  property p_no_zone;
    (pages == 4'h0) |-> !o_boot_start && (o_reset_vector == 16'h0000);
  endproperty
  property p_launch;
    $rose(o_cpu_stall) |-> $past(i_reg_wr) && ($past(i_reg_addr) == fsp_pkg::ADDR_CTRL);
  endproperty
  property p_req;
    $rose(o_cpu_stall) && !zone_erase |-> ##[0:1] o_flash_req;
  endproperty
  property p_req_busy;
    o_flash_req |-> o_cpu_stall;
  endproperty
  property p_done;
    s_finish |-> ##[1:2] !o_cpu_stall;
  endproperty
  property p_ctrl_unused;
    i_reg_rd && (i_reg_addr == fsp_pkg::ADDR_CTRL) |-> o_reg_rdata[6:2] == 5'h00;
  endproperty
  property p_sys_bits;
    s_sys_write |=> (o_ale_inhibit == $past(i_reg_wdata[0]))
                    && (o_xram_enable == $past(i_reg_wdata[1]));
  endproperty
  property p_page_span;
    o_flash_req && (o_flash_cmd.func == fsp_pkg::FSP_FN_PAGE_ERASE) |->
      (o_erase_lo == {o_flash_cmd.addr[15:9], 9'h000})
      && (o_erase_hi == {o_flash_cmd.addr[15:9], 9'h1ff});
  endproperty
  property p_chip_span;
    o_flash_req && (o_flash_cmd.func == fsp_pkg::FSP_FN_CHIP_ERASE) && (pages != 4'h0)
      |-> o_erase_hi == base - 16'h0001;
  endproperty
  property p_pp_erase;
    $rose(i_pp_erase) |-> ##[1:4] o_flash_full_erase;
  endproperty
  a_vector: assert property (p_vector) else $error("reset vector not at zone base");
  a_no_zone: assert property (p_no_zone) else $error("boot redirect with zero pages");
  a_launch: assert property (p_launch) else $error("busy without start write");
  a_req: assert property (p_req) else $error("no array request after launch");
  a_req_busy: assert property (p_req_busy) else $error("request while idle");
  a_done: assert property (p_done) else $error("busy after array done");
  a_ctrl_unused: assert property (p_ctrl_unused) else $error("unused bits not zero");
  a_sys_bits: assert property (p_sys_bits) else $error("system bits not applied");
  a_page_span: assert property (p_page_span) else $error("page erase span wrong");
  a_chip_span: assert property (p_chip_span) else $error("chip erase hits zone");
  a_pp_erase: assert property (p_pp_erase) else $error("programmer erase not seen");
endmodule

bind fsp_ctrl fsp_ctrl_checker #(.OP_CYCLES(OP_CYCLES)) fsp_ctrl_checker_i (
  .i_clock(i_clock), .i_nrst(i_nrst), .i_reg_addr(i_reg_addr), .i_reg_wr(i_reg_wr),
  .i_reg_rd(i_reg_rd), .i_reg_wdata(i_reg_wdata), .o_reg_rdata(o_reg_rdata),
  .i_boot_pages(i_boot_pages), .i_pp_erase(i_pp_erase), .o_boot_start(o_boot_start),
  .o_reset_vector(o_reset_vector), .o_cpu_stall(o_cpu_stall), .o_xram_enable(o_xram_enable),
  .o_ale_inhibit(o_ale_inhibit), .o_flash_req(o_flash_req), .o_flash_cmd(o_flash_cmd),
  .o_flash_full_erase(o_flash_full_erase), .o_erase_lo(o_erase_lo),
  .o_erase_hi(o_erase_hi), .i_flash_done(i_flash_done));

// File: tb/fsp_flash_model.sv
// fsp_flash_model: flash array stand-in answering each request with one done pulse
// assumes: one request outstanding at a time, delay set by the bench
`timescale 1ns/1ns
module fsp_flash_model (
  input  wire logic       i_clock,
  input  wire logic       i_nrst,
  input  wire logic       i_req,
  input  wire logic [3:0] i_delay,
  output logic            o_done
);
  logic [4:0] count_reg;
  always_ff @(posedge i_clock or negedge i_nrst) begin
    if (!i_nrst) begin
      count_reg <= 5'h00;
      o_done <= 1'b0;
    end else begin
      o_done <= (count_reg == 5'h01);
      if (i_req) count_reg <= {1'b0, i_delay} + 5'h02;
      else if (count_reg != 5'h00) count_reg <= count_reg - 5'h01;
    end
  end
endmodule

// File: tb/fsp_ctrl_bench.sv
// fsp_ctrl_bench: self-checking bench for the flash self-program controller
// assumes: flash array model on the far side; straps change only in reset
`timescale 1ns/1ns
module fsp_ctrl_bench;
  logic clk = 0, nrst = 0, wr = 0, rd = 0, wdt = 0, lock = 0, pp = 0, hit_seen;
  logic [7:0] addr = 8'h00, wdata = 8'h00, rdata, loc0 = 8'hff, rv;
  logic [3:0] pages = 4'h0, delay = 4'h0;
  logic [15:0] vec, a;
  logic boot, stall, xram, ale, rblock, req, full, done, hv;
  fsp_pkg::fsp_cmd_s cmd, last;
  logic [11:0] tbl [5] = '{12'h0ff, 12'h8ff, 12'hcff, 12'h500, 12'h3ff};
  logic [31:0] seed;
  int errors = 0, total_checks = 0, nreq = 0;
  always #2 clk = ~clk;
  fsp_ctrl #(.OP_CYCLES(8)) fsp_ctrl_i (.i_clock(clk), .i_nrst(nrst), .i_reg_addr(addr),
    .i_reg_wr(wr), .i_reg_rd(rd), .i_reg_wdata(wdata), .o_reg_rdata(rdata), .o_reg_hit(hit_seen),
    .i_wdt_reset(wdt), .i_boot_pages(pages), .i_lock_bit(lock), .i_flash_loc0(loc0),
    .i_pp_erase(pp), .o_boot_start(boot), .o_reset_vector(vec), .o_cpu_stall(stall),
    .o_xram_enable(xram), .o_ale_inhibit(ale), .o_read_block(rblock), .o_flash_req(req),
    .o_flash_cmd(cmd), .o_flash_full_erase(full), .o_erase_lo(), .o_erase_hi(),
    .i_flash_done(done));
  fsp_flash_model fsp_flash_model_i (.i_clock(clk), .i_nrst(nrst), .i_req(req),
    .i_delay(delay), .o_done(done));
  always @(posedge clk) if (req) begin
    last <= cmd;
    nreq <= nreq + 1;
  end
  // ==========================================================
  // helpers
  function automatic logic [31:0] rnd();
    seed ^= seed << 13;
    seed ^= seed >> 17;
    seed ^= seed << 5;
    return seed;
  endfunction
  function automatic logic [15:0] exp_vec(logic [3:0] p, logic [7:0] l0);
    if (p == 4'h0 || l0 != 8'hff) return 16'h0000;
    return 16'h0000 - {3'h0, (p > 4'h8) ? 4'h8 : p, 9'h000};
  endfunction
  task automatic check(string name, logic [31:0] seen, logic [31:0] exp);
    total_checks++;
    if (seen !== exp) begin
      errors++;
      $display("[FAIL] %s expected %h seen %h", name, exp, seen);
    end
  endtask
  task automatic print_verdict();
    $display("checks %0d mismatches %0d", total_checks, errors);
    if (errors == 0 && total_checks > 0) $display("Testbench passed");
    else $display("Testbench failed");
    $finish;
  endtask
  task automatic wr_reg(logic [7:0] ad, logic [7:0] d);
    @(posedge clk);
    addr <= ad;
    wdata <= d;
    wr <= 1'b1;
    @(posedge clk);
    wr <= 1'b0;
  endtask
  task automatic rd_reg(logic [7:0] ad);
    @(posedge clk);
    addr <= ad;
    rd <= 1'b1;
    @(posedge clk);
    rv = rdata;
    hv = hit_seen;
    rd <= 1'b0;
  endtask
  task automatic do_reset(logic [11:0] t);
    nrst <= 1'b0;
    pages <= t[11:8];
    loc0 <= t[7:0];
    lock <= t[8];
    repeat (12) @(posedge clk);
    nrst <= 1'b1;
    repeat (3) @(posedge clk);
  endtask
  task automatic launch(logic [1:0] fn, logic [15:0] ad, logic unlock, logic en);
    wr_reg(fsp_pkg::ADDR_ADDR_HIGH, ad[15:8]);
    wr_reg(fsp_pkg::ADDR_ADDR_LOW, ad[7:0]);
    if (unlock) begin
      wr_reg(fsp_pkg::ADDR_DATA, 8'h55);
      wr_reg(fsp_pkg::ADDR_DATA, 8'haa);
      wr_reg(fsp_pkg::ADDR_DATA, 8'h55);
    end
    wr_reg(fsp_pkg::ADDR_SYS_CTRL, {5'h00, en, 2'h0});
    wr_reg(fsp_pkg::ADDR_CTRL, {6'h20, fn});
    @(posedge clk);
  endtask
  task automatic wait_idle();
    int n;
    n = 0;
    while (stall !== 1'b0 && n < 100) begin
      @(posedge clk);
      n++;
    end
    if (n == 100) begin
      errors++;
      print_verdict();
    end
  endtask
  // ==========================================================
  // main sequence
  initial begin
    seed = 32'h980a;
    foreach (tbl[i]) begin
      do_reset(tbl[i]);
      check("vector", vec, exp_vec(tbl[i][11:8], tbl[i][7:0]));
      check("boot", boot, exp_vec(tbl[i][11:8], tbl[i][7:0]) != 16'h0000);
      check("readblock", rblock, tbl[i][8]);
    end
    $display("test straps done");
    rd_reg(fsp_pkg::ADDR_SYS_CTRL);
    check("sysctl", rv, 8'h00);
    rd_reg(8'h20);
    check("unmapped", {hv, rv}, 9'h000);
    wr_reg(fsp_pkg::ADDR_SYS_CTRL, 8'h03);
    // let the write settle before looking at the outputs
    @(negedge clk);
    check("xram_ale", {xram, ale}, 2'b11);
    // no unlock yet since reset, so this start must be refused
    launch(2'h0, 16'h1234, 1'b0, 1'b1);
    check("no_unlock", stall, 1'b0);
    launch(2'h0, 16'h1234, 1'b1, 1'b0);
    check("no_enable", stall, 1'b0);
    $display("test refusals done");
    repeat (3) for (int fn = 0; fn < 4; fn++) begin
      a = 16'(rnd());
      if (fn == 2) a = {1'b0, a[14:8], 8'h00};
      delay <= 4'(rnd() % 6);
      launch(2'(fn), a, 1'b1, 1'b1);
      wait_idle();
      check("cmd", last, {2'(fn), a, 8'h55});
      rd_reg(fsp_pkg::ADDR_CTRL);
      check("go_clear", rv, {6'h00, 2'(fn)});
      check("hit", hv, 1'b1);
    end
    a = 16'(nreq);
    launch(2'h2, 16'hfc00, 1'b1, 1'b1);
    wait_idle();
    check("zone_erase", nreq, a);
    $display("test operations done");
    wdt <= 1'b1;
    pp <= 1'b1;
    repeat (5) @(posedge clk);
    wdt <= 1'b0;
    check("full_erase", full, 1'b1);
    rd_reg(fsp_pkg::ADDR_SYS_CTRL);
    check("wdr", rv[7], 1'b1);
    $display("test reset cause done");
    print_verdict();
  end
endmodule
